//--- sram_ctrl_regs.svh
// Constants for the pipelined burst SRAM control block
`ifndef SRAM_CTRL_REGS_SVH
`define SRAM_CTRL_REGS_SVH

// ==========================================================
// Geometry
`define SRAM_ADDR_W   15
`define SRAM_DATA_W   32
`define SRAM_LANES    4
`define SRAM_LANE_W   8
`define SRAM_BURST_W  2

// ==========================================================
// Reset values
`define SRAM_ADDR_RST  15'h0000
`define SRAM_COUNT_RST 2'h0
`define SRAM_DATA_RST  32'h0000_0000

`endif

//--- sram_ctrl_pkg.sv
// Types shared by the burst SRAM control block
`default_nettype none
`include "sram_ctrl_regs.svh"
package sram_ctrl_pkg;

	// ==========================================================
	// Synchronous control pins, sampled on the rising edge
	typedef struct packed {
		logic                      chip_enable_n;
		logic                      select_high;
		logic                      select_low_n;
		logic                      processor_addr_strobe_n;
		logic                      controller_addr_strobe_n;
		logic                      burst_step_n;
		logic                      all_bytes_write_n;
		logic                      lane_write_gate_n;
		logic [`SRAM_LANES-1:0]    lane_write_sel_n;
	} bus_ctrl_s;

	// ==========================================================
	// Decoded cycle type
	typedef enum logic [2:0] {
		OP_NONE,
		OP_DESELECT,
		OP_START_READ,
		OP_START_CTRL,
		OP_CONTINUE,
		OP_SUSPEND
	} cycle_op_e;

endpackage
`default_nettype wire

//--- sram_word_mem.sv
// Byte-lane writable word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sram_word_mem #(
	parameter int ADDR_W = 15,
	parameter int LANE_W = 8,
	parameter int LANES  = 4
) (
	input  wire logic                      clock,
	input  wire logic                      rst_b,
	input  wire logic                      clk_en,
	input  wire logic [ADDR_W-1:0]         addr,
	input  wire logic                      rd_en,
	input  wire logic [LANES-1:0]          wr_lane,
	input  wire logic [LANES*LANE_W-1:0]   wr_data,
	output logic      [LANES*LANE_W-1:0]   rd_data
);

	logic [LANES*LANE_W-1:0] mem_array [0:(1<<ADDR_W)-1];

	// ==========================================================
	// Lane writes
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		always_ff @(posedge clock) begin
			if (clk_en && wr_lane[g]) begin
				mem_array[addr][g*LANE_W +: LANE_W] <= wr_data[g*LANE_W +: LANE_W];
			end
		end
	end

	// ==========================================================
	// Read register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= '0;
		end else if (clk_en && rd_en) begin
			rd_data <= mem_array[addr];
		end
	end

endmodule // sram_word_mem
`default_nettype wire

//--- pipelined_burst_sram_control.sv
// Synchronous control of a pipelined burst SRAM with byte-lane writes
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_regs.svh"
module pipelined_burst_sram_control #(
	parameter int ADDR_W = `SRAM_ADDR_W,
	parameter int LANE_W = `SRAM_LANE_W,
	parameter int LANES  = `SRAM_LANES
) (
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	input  wire logic                        clk_en,
	input  wire logic [ADDR_W-1:0]           addr,
	input  wire sram_ctrl_pkg::bus_ctrl_s    ctrl,
	input  wire logic                        output_drive_n,
	input  wire logic                        sleep_request,
	input  wire logic                        linear_order_sel_n,
	input  wire logic [LANES*LANE_W-1:0]     data_in,
	output logic      [LANES*LANE_W-1:0]     data_out,
	output logic                             data_oe
);
	import sram_ctrl_pkg::*;

	localparam int DATA_W = LANES * LANE_W;

	// ==========================================================
	// State
	typedef struct packed {
		logic [ADDR_W-1:0]            base;
		logic [`SRAM_BURST_W-1:0]     count;
		logic                         active;
		logic                         rd_pending;
		logic                         rd_valid;
		logic [DATA_W-1:0]            dout;
	} ctrl_state_s;

	ctrl_state_s state_reg;
	ctrl_state_s state_next;

	cycle_op_e                  op;
	logic                       chip_on;
	logic                       selected;
	logic                       write_req;
	logic [LANES-1:0]           lane_req;
	logic [`SRAM_BURST_W-1:0]   step_count;
	logic [ADDR_W-1:0]          step_base;
	logic [ADDR_W-1:0]          mem_addr;
	logic                       mem_rd;
	logic [LANES-1:0]           mem_wr;
	logic [DATA_W-1:0]          mem_rd_data;
	logic                       deselect_hit;
	logic                       write_cycle;
	logic                       drive_ok;

	// ==========================================================
	// Cycle decode
	always_comb begin
		chip_on  = !ctrl.chip_enable_n;
		selected = ctrl.select_high && !ctrl.select_low_n;
		// Global write overrides lane selects
		if (!ctrl.all_bytes_write_n) begin
			lane_req = '1;
		end else if (!ctrl.lane_write_gate_n) begin
			lane_req = ~ctrl.lane_write_sel_n;
		end else begin
			lane_req = '0;
		end
		write_req = |lane_req;
		// Controller strobe deselects even with the chip disabled; processor strobe does not
		deselect_hit = (!chip_on && !ctrl.controller_addr_strobe_n) ||
			(chip_on && !selected && (!ctrl.processor_addr_strobe_n ||
			!ctrl.controller_addr_strobe_n));
		// Deselect outranks both starts, and both starts outrank burst step
		if (sleep_request) begin
			op = OP_NONE;
		end else if (deselect_hit) begin
			op = OP_DESELECT;
		end else if (chip_on && selected && !ctrl.processor_addr_strobe_n) begin
			op = OP_START_READ;
		end else if (chip_on && selected && !ctrl.controller_addr_strobe_n) begin
			op = OP_START_CTRL;
		end else if (!ctrl.burst_step_n) begin
			op = OP_CONTINUE;
		end else begin
			op = OP_SUSPEND;
		end
	end

	// ==========================================================
	// Burst address
	always_comb begin
		case (op)
			OP_START_READ, OP_START_CTRL: begin
				step_base  = addr;
				step_count = `SRAM_COUNT_RST;
			end
			OP_CONTINUE: begin
				step_base  = state_reg.base;
				// Two-bit counter wraps after the fourth word
				step_count = 2'(state_reg.count + 2'h1);
			end
			default: begin
				step_base  = state_reg.base;
				step_count = state_reg.count;
			end
		endcase
		mem_addr = step_base;
		if (linear_order_sel_n) begin
			mem_addr[1:0] = step_base[1:0] ^ step_count;
		end else begin
			// Linear order carries only within the low two bits
			mem_addr[1:0] = 2'(step_base[1:0] + step_count);
		end
	end

	// ==========================================================
	// Access control
	always_comb begin
		mem_rd = 1'b0;
		mem_wr = '0;
		case (op)
			OP_START_READ: begin
				// Writes are blocked on a processor-strobed start
				mem_rd = 1'b1;
			end
			OP_START_CTRL: begin
				mem_wr = lane_req;
				mem_rd = !write_req;
			end
			OP_CONTINUE: begin
				// Bursts after deselect have no base, so nothing happens
				mem_wr = state_reg.active ? lane_req : '0;
				mem_rd = state_reg.active && !write_req;
			end
			OP_SUSPEND: begin
				mem_wr = state_reg.active ? lane_req : '0;
				mem_rd = state_reg.active && !write_req;
			end
			default: begin
				mem_rd = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		case (op)
			OP_DESELECT: begin
				state_next.active = 1'b0;
			end
			OP_START_READ, OP_START_CTRL, OP_CONTINUE, OP_SUSPEND: begin
				// Starts always reload; continue and suspend need a live burst
				if (op == OP_START_READ || op == OP_START_CTRL || state_reg.active) begin
					state_next.base   = step_base;
					state_next.count  = step_count;
					state_next.active = 1'b1;
				end
			end
			default: begin
				state_next.active = state_reg.active;
			end
		endcase
		// Sleep freezes the pipeline so held data survives the nap
		if (!sleep_request) begin
			state_next.rd_pending = mem_rd;
			state_next.rd_valid   = state_reg.rd_pending;
			if (state_reg.rd_pending) begin
				state_next.dout = mem_rd_data;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			// Memory contents are kept; only burst and pipeline state clear
			state_reg <= '{
				base:       `SRAM_ADDR_RST,
				count:      `SRAM_COUNT_RST,
				active:     1'b0,
				rd_pending: 1'b0,
				rd_valid:   1'b0,
				dout:       `SRAM_DATA_RST
			};
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Word store
	// Read port registers the word; dout adds the pipeline stage
	sram_word_mem #(
		.ADDR_W (ADDR_W),
		.LANE_W (LANE_W),
		.LANES  (LANES)
	) u_mem (
		.clock   (clock),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.addr    (mem_addr),
		.rd_en   (mem_rd),
		.wr_lane (mem_wr),
		.wr_data (data_in),
		.rd_data (mem_rd_data)
	);

	// ==========================================================
	// Pin direction
	// A processor start ignores the write pins, so only real writes turn the pins
	always_comb begin
		write_cycle = |mem_wr;
		drive_ok    = state_reg.rd_valid && !output_drive_n;
	end

	// ==========================================================
	// Pins
	// Read data holds between words so a stalled master can still take it
	assign data_out = state_reg.dout;
	// Enable stays combinational: the drive enable acts without the clock
	assign data_oe  = drive_ok && !sleep_request && !write_cycle;

endmodule // pipelined_burst_sram_control
`default_nettype wire

//--- burst_sram_properties.sv
// Port-level checks of the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module burst_sram_properties #(
	parameter int LANE_W = 8,
	parameter int LANES  = 4
) (
	input wire logic                     clock,
	input wire logic                     rst_b,
	input wire logic                     clk_en,
	input wire sram_ctrl_pkg::bus_ctrl_s ctrl,
	input wire logic                     output_drive_n,
	input wire logic                     sleep_request,
	input wire logic [LANES*LANE_W-1:0]  data_out,
	input wire logic                     data_oe
);
	import sram_ctrl_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Decode of the sampled bus cycle
	logic ce, pa, ca, sel, ds, wr, tk, rt;
	logic burst_on, wc;
	assign ce = !ctrl.chip_enable_n;
	assign pa = !ctrl.processor_addr_strobe_n;
	assign ca = !ctrl.controller_addr_strobe_n;
	assign sel = ce && ctrl.select_high && !ctrl.select_low_n;
	assign ds = ce ? !sel && (pa || ca) : ca;
	assign wr = !ctrl.all_bytes_write_n || (!ctrl.lane_write_gate_n && !(&ctrl.lane_write_sel_n));
	assign tk = clk_en && !sleep_request;
	// Processor start reads even with write pins low
	assign rt = tk && !ds && ((sel && pa) || !wr);
	// Mirror of a live burst, to tell a real write cycle from an ignored one
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			burst_on <= 1'b0;
		end else if (tk && ds) begin
			burst_on <= 1'b0;
		end else if (tk && sel && (pa || ca)) begin
			burst_on <= 1'b1;
		end
	end
	// Write cycle: processor start never writes, continue and suspend only in a burst
	assign wc = !sleep_request && !ds && !(sel && pa) && wr && ((sel && ca) || burst_on);
	AST_DRIVE_GATE: assert property (output_drive_n |-> !data_oe)
		else $error("pins driven with drive off");
	AST_SLEEP_FLOAT: assert property (sleep_request |-> !data_oe)
		else $error("pins driven in sleep");
	AST_WRITE_INPUT: assert property (wc |-> !data_oe)
		else $error("pins driven in write");
	AST_DESELECT: assert property ((tk && ds) ##1 tk |=> !data_oe)
		else $error("pins driven after deselect");
	AST_READ_LATENCY: assert property ((tk && sel && pa) ##1 tk |=>
		data_oe || output_drive_n || wc || sleep_request) else $error("read word missing");
	AST_WRITE_NO_READ: assert property ((tk && sel && !pa && ca && wr) ##1 tk |=> !data_oe)
		else $error("write start gave read data");
	AST_SLEEP_FREEZE: assert property (!tk |=> $stable(data_out))
		else $error("data changed while frozen");
	AST_DATA_CAUSE: assert property (!$stable(data_out) |-> $past(rt, 2) && $past(tk))
		else $error("data changed without a read");
endmodule // burst_sram_properties
bind pipelined_burst_sram_control burst_sram_properties #(.LANE_W(LANE_W), .LANES(LANES)) props_u (
	.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .ctrl(ctrl), .output_drive_n(output_drive_n),
	.sleep_request(sleep_request), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

//--- bus_master_model.sv
// Bus master standing for the processor or cache controller
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	input  wire logic                    clock,
	output logic [14:0]                  addr,
	output var sram_ctrl_pkg::bus_ctrl_s ctrl,
	output logic [31:0]                  data_in,
	output logic                         sleep_request
);
	import sram_ctrl_pkg::*;
	initial begin
		ctrl = 12'hBFF;
		addr = 15'h0000;
		data_in = 32'h0000_0000;
		sleep_request = 1'b0;
	end
	// Unwritten data toggles, so a stale word never passes
	task automatic cyc(input bus_ctrl_s c, input logic [14:0] a = 15'h7FFF,
		input logic [31:0] d = 32'h0000_0000, input logic nap = 1'b0);
		@(negedge clock);
		ctrl <= c;
		addr <= a;
		sleep_request <= nap;
		data_in <= (c.all_bytes_write_n && c.lane_write_gate_n) ? ~data_in : d;
		#1;
	endtask
endmodule // bus_master_model
`default_nettype wire

//--- testbench.sv
// Self-checking testbench of the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sram_ctrl_pkg::*;
	// Starts, continue, suspend, deselect; W marks a write
	localparam bus_ctrl_s PRD = 12'h4DF, CRD = 12'h57F, CWR = 12'h55F, CNT = 12'hBBF;
	localparam bus_ctrl_s CNW = 12'hB9F, SUS = 12'hBFF, SLW = 12'hBE5, SGW = 12'hBDF, DSL = 12'hB7F;
	logic        clock, rst_b, clk_en, output_drive_n, linear_order_sel_n, sleep_request, data_oe;
	logic [14:0] addr;
	logic [31:0] data_in, data_out, mem [16];
	bus_ctrl_s   ctrl;
	int          fails, n_compared;
	pipelined_burst_sram_control dut_u (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.addr(addr), .ctrl(ctrl), .output_drive_n(output_drive_n), .sleep_request(sleep_request),
		.linear_order_sel_n(linear_order_sel_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe));
	bus_master_model master_u (.clock(clock), .addr(addr), .ctrl(ctrl), .data_in(data_in),
		.sleep_request(sleep_request));
	always #12.5 clock = ~clock;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_reset(input logic lin_n);
		rst_b = 1'b0;
		linear_order_sel_n = lin_n;
		repeat (20) @(negedge clock);
		rst_b = 1'b1;
	endtask
	task automatic t_fill();
		for (int i = 0; i < 16; i++) begin
			mem[i] = 32'h1357_9BDF ^ (32'(i) * 32'h0101_0101);
			master_u.cyc(CWR, 15'h0100 + 15'(i), mem[i]);
		end
	endtask
	// Read word k lands two calls after its edge; a fifth step shows the wrap
	task automatic t_burst(input logic [14:0] a);
		logic [1:0] k;
		master_u.cyc(PRD, a);
		master_u.cyc(CNT);
		for (int i = 0; i < 5; i++) begin
			master_u.cyc(CNT);
			k = linear_order_sel_n ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
			chk(data_out, mem[{a[3:2], k}]);
			chk(32'(data_oe), 32'h1);
		end
	endtask
	task automatic t_write();
		master_u.cyc(CRD, 15'h0104);
		master_u.cyc(CNW, 15'h7FFF, 32'h1122_3344);
		master_u.cyc(SLW, 15'h7FFF, 32'hCAFE_F00D);
		mem[5] = 32'hCA22_F044;
		t_burst(15'h0105);
	endtask
	// Clock enable low across a write start must leave burst, memory and pipeline as they were
	task automatic t_freeze();
		master_u.cyc(PRD, 15'h0109);
		repeat (2) master_u.cyc(SUS);
		clk_en = 1'b0;
		master_u.cyc(CWR, 15'h0109, 32'h5A5A_5A5A);
		master_u.cyc(SUS);
		clk_en = 1'b1;
		master_u.cyc(SUS);
		chk(data_out, mem[9]);
		master_u.cyc(SUS);
		chk(data_out, mem[9]);
		chk(32'(data_oe), 32'h1);
	endtask
	task automatic t_float();
		master_u.cyc(PRD, 15'h0100);
		repeat (3) master_u.cyc(SUS);
		chk(data_out, mem[0]);
		output_drive_n = 1'b1;
		#1 chk(32'(data_oe), 32'h0);
		master_u.cyc(SUS);
		chk(32'(data_oe), 32'h0);
		output_drive_n = 1'b0;
		#1 chk(32'(data_oe), 32'h1);
		repeat (3) master_u.cyc(DSL);
		chk(32'(data_oe), 32'h0);
		master_u.cyc(PRD, 15'h0100);
		master_u.cyc(SUS);
		master_u.cyc(SGW, 15'h7FFF, 32'h0F0F_0F0F);
		chk(32'(data_oe), 32'h0);
		mem[0] = 32'h0F0F_0F0F;
		master_u.cyc(DSL);
		master_u.cyc(PRD, 15'h0102, 32'h0000_0000, 1'b1);
		repeat (3) master_u.cyc(SUS);
		chk(32'(data_oe), 32'h0);
	endtask
	task automatic complete_run();
		$display("Compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		clk_en = 1'b1;
		output_drive_n = 1'b0;
		fails = 0;
		n_compared = 0;
		do_reset(1'b1);
		t_fill();
		t_burst(15'h0101);
		t_burst(15'h010E);
		t_write();
		t_freeze();
		t_float();
		do_reset(1'b0);
		t_burst(15'h0103);
		t_burst(15'h0106);
		complete_run();
	end
	initial begin
		#100000;
		fails++;
		complete_run();
	end
endmodule // testbench
`default_nettype wire
